//--- verilog/rfq_top.sv
// Ring frequency qualifier: APB register file, qualification timer, burst timeout,
// confirmation and indication delay, interrupt status.
// Assumes RING_EVT_I is a one-cycle pulse per line threshold crossing, synchronous to CLK_SYS_I.
//
// Overview of operation
// - Each threshold event reloads the countdown from assertion time; it then counts down per tick.
// - A later event after countdown expiry means frequency too low; ring invalidated.
// - A later event with remaining count above max count means too high; invalidated.
// - Countdown unit is 2 ms; assertion minus max count sets minimum event spacing.
// - No crossing for the coded timeout ends the burst: 80 ms, then 128 ms steps.
// - Qualification runs only while the enable bit is set; clearing it resets the qualifier and the tick.
// - Ring is valid only after staying in tolerance for the confirmation time.
// - After validation, wait the 256 ms step delay before indicating a valid ring.
`include "rfq_consts.svh"

module rfq_top #(
  parameter int unsigned TICK_CYCLES = `RFQ_TICK_CYCLES
) (
  input wire logic CLK_SYS_I,
  input wire logic RST_N_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [31:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic RING_EVT_I,
  output logic RING_VALID_O,
  output logic IRQ_O
);

  localparam int CW = `RFQ_CNT_W;

  function automatic logic [CW-1:0] tmo_ticks(input logic [3:0] code);
    tmo_ticks = (code == 4'h0) ? `RFQ_TMO_BASE_TICKS : CW'(`RFQ_TMO_STEP_TICKS * code);
  endfunction : tmo_ticks

  // Codes 010..100 fall between the listed points
  function automatic logic [CW-1:0] confirm_ticks(input logic [2:0] code);
    unique case (code)
      3'h0: confirm_ticks = `RFQ_CONFIRM_T0;
      3'h1: confirm_ticks = `RFQ_CONFIRM_T1;
      3'h2: confirm_ticks = `RFQ_CONFIRM_T2;
      3'h3: confirm_ticks = `RFQ_CONFIRM_T3;
      3'h4: confirm_ticks = `RFQ_CONFIRM_T4;
      3'h5: confirm_ticks = `RFQ_CONFIRM_T5;
      3'h6: confirm_ticks = `RFQ_CONFIRM_T6;
      3'h7: confirm_ticks = `RFQ_CONFIRM_T7;
    endcase
  endfunction : confirm_ticks

  function automatic logic [CW-1:0] delay_ticks(input logic [2:0] code);
    delay_ticks = CW'(`RFQ_DELAY_STEP_TICKS * code);
  endfunction : delay_ticks

  // Registers
  logic [7:0] assert_time_r, assert_time_nxt;
  logic [7:0] tmo_maxcnt_r, tmo_maxcnt_nxt;
  logic [7:0] valid_ctrl_r, valid_ctrl_nxt;
  rfq_pkg::rfq_evt_t irq_stat_r, irq_stat_nxt;
  rfq_pkg::rfq_evt_t irq_en_r, irq_en_nxt;
  logic [31:0] prdata_nxt;
  logic pready_nxt, pslverr_nxt, irq_nxt;

  // Qualifier state
  rfq_pkg::rfq_state_t state_r, state_nxt;
  logic [5:0] qual_r, qual_nxt;
  logic expired_r, expired_nxt;
  logic seen_r, seen_nxt;
  logic [CW-1:0] burst_r, burst_nxt;
  logic [CW-1:0] seq_r, seq_nxt;
  logic ring_valid_nxt;
  rfq_pkg::rfq_evt_t evt;

  logic tick;
  logic enable;
  logic setup, wr_acc;
  logic [7:0] addr;

  assign enable = valid_ctrl_r[`RFQ_ENABLE_BIT];
  assign setup = PSEL_I && !PENABLE_I;
  assign wr_acc = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I;
  assign addr = PADDR_I[7:0];

  rfq_tick_div #(
    .CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk_i(CLK_SYS_I),
    .rst_n_i(RST_N_I),
    .en_i(enable),
    .tick_o(tick)
  );

  // Qualification
  always_comb begin
    state_nxt = state_r;
    qual_nxt = qual_r;
    expired_nxt = expired_r;
    seen_nxt = seen_r;
    burst_nxt = burst_r;
    seq_nxt = seq_r;
    ring_valid_nxt = RING_VALID_O;
    evt = '0;
    if (!enable) begin
      state_nxt = rfq_pkg::RFQ_IDLE;
      qual_nxt = '0;
      expired_nxt = 1'b0;
      seen_nxt = 1'b0;
      burst_nxt = '0;
      seq_nxt = '0;
      ring_valid_nxt = 1'b0;
    end else if (RING_EVT_I) begin
      qual_nxt = assert_time_r[`RFQ_ASSERT_MSB:`RFQ_ASSERT_LSB];
      expired_nxt = 1'b0;
      seen_nxt = 1'b1;
      burst_nxt = '0;
      if (seen_r && expired_r) begin
        evt.too_low = 1'b1;
      end else if (seen_r && (qual_r > {2'b00, tmo_maxcnt_r[`RFQ_MAXCNT_MSB:`RFQ_MAXCNT_LSB]})) begin
        evt.too_high = 1'b1;
      end
      if (evt.too_low || evt.too_high) begin
        // Out of tolerance restarts confirmation
        state_nxt = rfq_pkg::RFQ_CONFIRM;
        seq_nxt = '0;
        ring_valid_nxt = 1'b0;
      end else if (state_r == rfq_pkg::RFQ_IDLE) begin
        state_nxt = rfq_pkg::RFQ_CONFIRM;
        seq_nxt = '0;
      end
    end else if (tick) begin
      if (qual_r > 6'h01) begin
        qual_nxt = qual_r - 6'h01;
      end else begin
        qual_nxt = '0;
        expired_nxt = seen_r;
      end
      burst_nxt = burst_r + CW'(1);
      if (seen_r && (burst_nxt >= tmo_ticks(tmo_maxcnt_r[`RFQ_TMO_MSB:`RFQ_TMO_LSB]))) begin
        evt.burst_end = 1'b1;
        state_nxt = rfq_pkg::RFQ_IDLE;
        seen_nxt = 1'b0;
        expired_nxt = 1'b0;
        qual_nxt = '0;
        burst_nxt = '0;
        seq_nxt = '0;
        ring_valid_nxt = 1'b0;
      end else begin
        unique case (state_r)
          rfq_pkg::RFQ_IDLE: begin
            seq_nxt = '0;
          end
          rfq_pkg::RFQ_CONFIRM: begin
            seq_nxt = seq_r + CW'(1);
            if (seq_nxt >= confirm_ticks(valid_ctrl_r[`RFQ_CONFIRM_MSB:`RFQ_CONFIRM_LSB])) begin
              seq_nxt = '0;
              state_nxt = rfq_pkg::RFQ_DELAY;
            end
          end
          rfq_pkg::RFQ_DELAY: begin
            if (seq_r >= delay_ticks(valid_ctrl_r[`RFQ_DELAY_MSB:`RFQ_DELAY_LSB])) begin
              state_nxt = rfq_pkg::RFQ_VALID;
              ring_valid_nxt = 1'b1;
              evt.valid_ring = 1'b1;
            end else begin
              seq_nxt = seq_r + CW'(1);
            end
          end
          rfq_pkg::RFQ_VALID: begin
            ring_valid_nxt = 1'b1;
          end
        endcase
      end
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state_r <= rfq_pkg::RFQ_IDLE;
      qual_r <= '0;
      expired_r <= 1'b0;
      seen_r <= 1'b0;
      burst_r <= '0;
      seq_r <= '0;
      RING_VALID_O <= 1'b0;
    end else begin
      state_r <= state_nxt;
      qual_r <= qual_nxt;
      expired_r <= expired_nxt;
      seen_r <= seen_nxt;
      burst_r <= burst_nxt;
      seq_r <= seq_nxt;
      RING_VALID_O <= ring_valid_nxt;
    end
  end

  // APB slave: answers in the first access cycle
  always_comb begin
    assert_time_nxt = assert_time_r;
    tmo_maxcnt_nxt = tmo_maxcnt_r;
    valid_ctrl_nxt = valid_ctrl_r;
    irq_en_nxt = irq_en_r;
    irq_stat_nxt = irq_stat_r;
    prdata_nxt = PRDATA_O;
    pslverr_nxt = PSLVERR_O;
    pready_nxt = setup;
    if (wr_acc && !PSLVERR_O) begin
      unique case (addr)
        `RFQ_OFS_ASSERT_TIME: assert_time_nxt = {2'b00, PWDATA_I[5:0]};
        `RFQ_OFS_TMO_MAXCNT: tmo_maxcnt_nxt = PWDATA_I[7:0];
        // Bit 0 is reserved and kept at zero
        `RFQ_OFS_VALID_CTRL: valid_ctrl_nxt = {PWDATA_I[7:1], 1'b0};
        `RFQ_OFS_IRQ_ENABLE: irq_en_nxt = rfq_pkg::rfq_evt_t'(PWDATA_I[3:0]);
        `RFQ_OFS_IRQ_CLEAR: irq_stat_nxt = irq_stat_r & ~rfq_pkg::rfq_evt_t'(PWDATA_I[3:0]);
        default: irq_stat_nxt = irq_stat_r;
      endcase
    end
    // New events win over a clear in the same cycle
    irq_stat_nxt = irq_stat_nxt | evt;
    if (setup) begin
      pslverr_nxt = 1'b0;
      prdata_nxt = '0;
      unique case (addr)
        `RFQ_OFS_ASSERT_TIME: prdata_nxt = {24'h000000, assert_time_r};
        `RFQ_OFS_TMO_MAXCNT: prdata_nxt = {24'h000000, tmo_maxcnt_r};
        `RFQ_OFS_VALID_CTRL: prdata_nxt = {24'h000000, valid_ctrl_r};
        `RFQ_OFS_STATUS: prdata_nxt = {16'h0000, 2'b00, qual_r, state_r, expired_r, seen_r, RING_VALID_O, enable};
        `RFQ_OFS_IRQ_STATUS: prdata_nxt = {28'h0000000, irq_stat_r};
        `RFQ_OFS_IRQ_CLEAR: prdata_nxt = '0;
        `RFQ_OFS_IRQ_ENABLE: prdata_nxt = {28'h0000000, irq_en_r};
        default: pslverr_nxt = 1'b1;
      endcase
    end
    irq_nxt = |(irq_stat_nxt & irq_en_nxt);
  end

  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      assert_time_r <= `RFQ_RST_ASSERT_TIME;
      tmo_maxcnt_r <= `RFQ_RST_TMO_MAXCNT;
      valid_ctrl_r <= `RFQ_RST_VALID_CTRL;
      irq_en_r <= `RFQ_RST_IRQ_ENABLE;
      irq_stat_r <= '0;
      PRDATA_O <= '0;
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
      IRQ_O <= 1'b0;
    end else begin
      assert_time_r <= assert_time_nxt;
      tmo_maxcnt_r <= tmo_maxcnt_nxt;
      valid_ctrl_r <= valid_ctrl_nxt;
      irq_en_r <= irq_en_nxt;
      irq_stat_r <= irq_stat_nxt;
      PRDATA_O <= prdata_nxt;
      PREADY_O <= pready_nxt;
      PSLVERR_O <= pslverr_nxt;
      IRQ_O <= irq_nxt;
    end
  end

endmodule : rfq_top

//--- verilog/rfq_consts.svh
// Offsets, field positions, reset values and timing counts of the ring frequency qualifier.
// Assumes 32-bit APB data with one aligned word per register.
`ifndef RFQ_CONSTS_SVH
`define RFQ_CONSTS_SVH

`define RFQ_ADDR_W 8
`define RFQ_OFS_ASSERT_TIME 8'h00
`define RFQ_OFS_TMO_MAXCNT 8'h04
`define RFQ_OFS_VALID_CTRL 8'h08
`define RFQ_OFS_STATUS 8'h0c
`define RFQ_OFS_IRQ_STATUS 8'h10
`define RFQ_OFS_IRQ_CLEAR 8'h14
`define RFQ_OFS_IRQ_ENABLE 8'h18

`define RFQ_RST_ASSERT_TIME 8'h19
`define RFQ_RST_TMO_MAXCNT 8'h16
`define RFQ_RST_VALID_CTRL 8'h88
`define RFQ_RST_IRQ_ENABLE 4'h0

`define RFQ_ASSERT_LSB 0
`define RFQ_ASSERT_MSB 5
`define RFQ_MAXCNT_LSB 0
`define RFQ_MAXCNT_MSB 3
`define RFQ_TMO_LSB 4
`define RFQ_TMO_MSB 7
`define RFQ_ENABLE_BIT 7
`define RFQ_DELAY_LSB 4
`define RFQ_DELAY_MSB 6
`define RFQ_CONFIRM_LSB 1
`define RFQ_CONFIRM_MSB 3

`define RFQ_CLK_HZ 100000000
`define RFQ_TICK_US 2000
`define RFQ_TICK_CYCLES (`RFQ_TICK_US * (`RFQ_CLK_HZ / 1000000))
`define RFQ_TMO_BASE_TICKS 10'h028
`define RFQ_TMO_STEP_TICKS 10'h040
`define RFQ_DELAY_STEP_TICKS 10'h080
`define RFQ_CONFIRM_T0 10'h032
`define RFQ_CONFIRM_T1 10'h04b
`define RFQ_CONFIRM_T2 10'h064
`define RFQ_CONFIRM_T3 10'h080
`define RFQ_CONFIRM_T4 10'h0c0
`define RFQ_CONFIRM_T5 10'h100
`define RFQ_CONFIRM_T6 10'h140
`define RFQ_CONFIRM_T7 10'h200
`define RFQ_CNT_W 10

`endif

//--- verilog/rfq_pkg.sv
// Types shared by the ring frequency qualifier modules.
// Assumes rfq_consts.svh is included before this package.
`include "rfq_consts.svh"

package rfq_pkg;

  typedef enum logic [3:0] {
    RFQ_IDLE    = 4'b0001,
    RFQ_CONFIRM = 4'b0010,
    RFQ_DELAY   = 4'b0100,
    RFQ_VALID   = 4'b1000
  } rfq_state_t;

  // Event vector, same layout in irq status, clear and enable
  typedef struct packed {
    logic valid_ring;
    logic burst_end;
    logic too_high;
    logic too_low;
  } rfq_evt_t;

endpackage : rfq_pkg

//--- verilog/rfq_tick_div.sv
// Divider making the one-cycle 2 ms timer tick of the ring qualifier.
// Assumes a single system clock; the tick restarts while disabled.
module rfq_tick_div #(
  parameter int unsigned CYCLES = 200000
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  output logic tick_o
);

  localparam int unsigned W = $clog2(CYCLES);
  localparam logic [W-1:0] LAST = W'(CYCLES - 1);

  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic tick_nxt;

  always_comb begin
    cnt_nxt = cnt_r + W'(1);
    tick_nxt = 1'b0;
    if (!en_i) begin
      cnt_nxt = '0;
    end else if (cnt_r == LAST) begin
      cnt_nxt = '0;
      tick_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= '0;
      tick_o <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick_o <= tick_nxt;
    end
  end

endmodule : rfq_tick_div

//--- verification/rfq_sva.sv
// Checker of the ring qualifier ports: bus timing, enable, burst end and tolerance drops.
// Assumes the rfq_top register offsets and a short TICK_CYCLES.
`include "rfq_consts.svh"
module rfq_sva #(
  parameter int unsigned TICK_CYCLES = 8
) (
  input wire logic CLK_SYS_I,
  input wire logic RST_N_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [31:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic PREADY_O,
  input wire logic PSLVERR_O,
  input wire logic RING_EVT_I,
  input wire logic RING_VALID_O
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wr;
  logic [7:0] vc_r;
  logic [5:0] asrt_r;
  logic [7:0] tm_r;
  logic [15:0] gap_r;
  logic [15:0] run_r;
  int unsigned lim;
  assign wr = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I;
  // One tick of slack for the unknown tick phase
  assign lim = (((tm_r[7:4] == 4'h0) ? 40 : 64 * tm_r[7:4]) + 1) * TICK_CYCLES + 4;
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      vc_r <= 8'h88;
      asrt_r <= 6'h19;
      tm_r <= 8'h16;
      gap_r <= 16'hffff;
      run_r <= 16'h0;
    end else begin
      if (wr && PADDR_I[7:0] == `RFQ_OFS_VALID_CTRL) vc_r <= PWDATA_I[7:0];
      if (wr && PADDR_I[7:0] == `RFQ_OFS_ASSERT_TIME) asrt_r <= PWDATA_I[5:0];
      if (wr && PADDR_I[7:0] == `RFQ_OFS_TMO_MAXCNT) tm_r <= PWDATA_I[7:0];
      gap_r <= (RING_EVT_I && vc_r[7]) ? 16'h0 : gap_r + {15'h0, gap_r != 16'hffff};
      run_r <= (RING_EVT_I && gap_r > lim) ? 16'h0 : run_r + {15'h0, run_r != 16'hffff};
    end
  end
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RST_N_I);
  AST_READY_PULSE: assert property (PREADY_O |=> !PREADY_O) else $error("ready longer than one cycle");
  AST_SETUP_READY: assert property (PSEL_I && !PENABLE_I |=> PREADY_O) else $error("no ready after setup");
  AST_SLVERR: assert property (PREADY_O && PADDR_I[1:0] == 2'b00 |-> PSLVERR_O == (PADDR_I[7:0] > 8'h18))
    else $error("error response wrong");
  AST_DISABLED: assert property (!vc_r[7] |-> ##1 !RING_VALID_O) else $error("valid while off");
  AST_TIMEOUT: assert property (RING_VALID_O |-> gap_r <= lim) else $error("valid past timeout");
  AST_CONFIRM: assert property ($rose(RING_VALID_O) |-> run_r >= (49 + 128 * vc_r[6:4]) * TICK_CYCLES)
    else $error("valid too early");
  AST_TOO_LOW: assert property (RING_VALID_O && RING_EVT_I && gap_r > (asrt_r + 2) * TICK_CYCLES
    |-> ##[1:2] !RING_VALID_O) else $error("slow event kept valid");
  AST_TOO_HIGH: assert property (RING_VALID_O && RING_EVT_I
    && gap_r + (tm_r[3:0] + 1) * TICK_CYCLES < asrt_r * TICK_CYCLES |-> ##[1:2] !RING_VALID_O)
    else $error("fast event kept valid");
endmodule : rfq_sva
bind rfq_top rfq_sva #(.TICK_CYCLES(TICK_CYCLES)) u_sva (.CLK_SYS_I(CLK_SYS_I), .RST_N_I(RST_N_I),
  .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
  .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .RING_EVT_I(RING_EVT_I), .RING_VALID_O(RING_VALID_O));

//--- verification/rfq_ring_src.sv
// Line-side threshold detector model: num_i one-cycle events, gap_i+1 cycles apart.
// Assumes go_i is a one-cycle pulse; the first event also waits one gap.
module rfq_ring_src (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic go_i,
  input wire logic [15:0] gap_i,
  input wire logic [7:0] num_i,
  output logic evt_o,
  output logic busy_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] left;
  logic [15:0] cnt;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      left <= 8'h0;
      cnt <= 16'h0;
      evt_o <= 1'b0;
    end else if (go_i) begin
      left <= num_i;
      cnt <= gap_i;
      evt_o <= 1'b0;
    end else begin
      evt_o <= (left != 8'h0) && (cnt == 16'h0);
      if (left != 8'h0) begin
        if (cnt == 16'h0) begin
          cnt <= gap_i;
          left <= left - 8'h1;
        end else cnt <= cnt - 16'h1;
      end
    end
  end
  assign busy_o = (left != 8'h0) || evt_o;
endmodule : rfq_ring_src

//--- verification/rfq_top_tb.sv
// Bench of rfq_top: register table, frequency tolerance, burst end and enable.
// Assumes rfq_ring_src as event source and an 8-cycle tick.
module rfq_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned TC = 8;
  typedef struct packed {
    logic w;
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] e;
    logic er;
  } rfq_row_t;
  localparam rfq_row_t ROWS [14] = '{
    '{1'b0, 8'h00, 32'h0, 32'h19, 1'b0}, '{1'b0, 8'h04, 32'h0, 32'h16, 1'b0},
    '{1'b0, 8'h08, 32'h0, 32'h88, 1'b0}, '{1'b0, 8'h18, 32'h0, 32'h0, 1'b0},
    '{1'b0, 8'h10, 32'h0, 32'h0, 1'b0}, '{1'b1, 8'h00, 32'hffffffff, 32'h0, 1'b0},
    '{1'b0, 8'h00, 32'h0, 32'h3f, 1'b0}, '{1'b0, 8'h40, 32'h0, 32'h0, 1'b1},
    '{1'b1, 8'h40, 32'h5, 32'h0, 1'b1}, '{1'b1, 8'h00, 32'h0a, 32'h0, 1'b0},
    '{1'b1, 8'h04, 32'h04, 32'h0, 1'b0}, '{1'b1, 8'h18, 32'h0f, 32'h0, 1'b0},
    '{1'b1, 8'h08, 32'h80, 32'h0, 1'b0}, '{1'b0, 8'h0c, 32'h0, 32'h11, 1'b0}};
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic ring_evt;
  logic ring_valid;
  logic irq;
  logic go = 1'b0;
  logic [15:0] gap = 16'h0;
  logic [7:0] num = 8'h0;
  logic busy;
  logic [31:0] rd;
  logic er;
  int n_mismatch = 0;
  int tests_run = 0;
  int cyc = 0;
  always #5 clk_sys = ~clk_sys;
  rfq_top #(.TICK_CYCLES(TC)) DUT (.CLK_SYS_I(clk_sys), .RST_N_I(rst_n), .PSEL_I(psel),
    .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .RING_EVT_I(ring_evt), .RING_VALID_O(ring_valid), .IRQ_O(irq));
  rfq_ring_src u_src (.clk_i(clk_sys), .rst_n_i(rst_n), .go_i(go), .gap_i(gap), .num_i(num),
    .evt_o(ring_evt), .busy_o(busy));
  task automatic give_verdict();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("[ERR] %s exp %h got %h", n, e, g);
      n_mismatch++;
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
    output logic r);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {24'h0, a};
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    q = prdata;
    r = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    logic r;
    apb(1'b0, a, 32'h0, q, r);
    chk(n, e, q);
  endtask : rchk
  // Waits until the model has sent its last event
  task automatic burst(input logic [7:0] k, input logic [15:0] g);
    @(posedge clk_sys);
    gap <= g - 16'h1;
    num <= k;
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
    @(posedge clk_sys);
    while (busy === 1'b1) @(posedge clk_sys);
  endtask : burst
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  initial begin
    repeat (2) @(posedge clk_sys);
    chk("rst_out", 32'h0, {28'h0, pready, pslverr, ring_valid, irq});
    rst_n <= 1'b1;
    // Event spacing 12 ms to 20 ms (6 to 10 ticks): assertion 10, max count 4
    for (int i = 0; i < 14; i++) begin
      apb(ROWS[i].w, ROWS[i].a, ROWS[i].d, rd, er);
      if (!ROWS[i].w) chk("row_rd", ROWS[i].e, rd);
      chk("row_err", {31'h0, ROWS[i].er}, {31'h0, er});
    end
    burst(8'd2, 16'(2 * TC));
    rchk("too_high", 8'h10, 32'h2);
    chk("irq_set", 32'h1, {31'h0, irq});
    apb(1'b1, 8'h14, 32'hf, rd, er);
    rchk("cleared", 8'h10, 32'h0);
    chk("irq_clr", 32'h0, {31'h0, irq});
    burst(8'd10, 16'(6 * TC));
    chk("valid", 32'h1, {31'h0, ring_valid});
    rchk("valid_irq", 8'h10, 32'h8);
    burst(8'd1, 16'(13 * TC));
    chk("low_drop", 32'h0, {31'h0, ring_valid});
    rchk("too_low", 8'h10, 32'h9);
    repeat (45 * TC) @(posedge clk_sys);
    rchk("burst_end", 8'h10, 32'hd);
    apb(1'b1, 8'h08, 32'h0, rd, er);
    apb(1'b1, 8'h14, 32'hf, rd, er);
    burst(8'd2, 16'(2 * TC));
    rchk("disabled", 8'h10, 32'h0);
    // Delay code 1; spacing on the tick grid so phase cannot flip the verdict
    apb(1'b1, 8'h08, 32'h90, rd, er);
    burst(8'd28, 16'(7 * TC));
    chk("dly_valid", 32'h1, {31'h0, ring_valid});
    burst(8'd1, 16'(2 * TC));
    chk("high_drop", 32'h0, {31'h0, ring_valid});
    rchk("high_irq", 8'h10, 32'ha);
    give_verdict();
  end
endmodule : rfq_top_tb
